// [bench/dmacm_chk.sv]
// dmacm_chk: port checks for dmacm_ctrl
// assumes one clock domain; bound below
`timescale 1ns/1ps
`default_nettype none
module dmacm_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire dmacm_pkg::dmacm_req_t req,
  input wire logic [7:0] rdata,
  input wire logic nmiN,
  input wire dmacm_pkg::dmacm_eng_t eng,
  input wire logic ch0Run,
  input wire logic ch1Run,
  input wire dmacm_pkg::dmacm_mode_t srcMode,
  input wire dmacm_pkg::dmacm_mode_t dstMode
);
  import dmacm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // status write decode
  wire logic sw = req.wr && req.addr == STATUS_ADDR;
  wire logic [7:0] d = req.wdata;
  sequence nmiFall;
    $fell(nmiN) ##1 (!nmiN && !req.wr) [*5];
  endsequence
  // register and event effects
  AST_GATE_RD: assert property (req.rd && req.addr == STATUS_ADDR |=> rdata[5:4] == 2'h3)
    else $error("gate read low");
  AST_CH1_SET: assert property (sw && d[7] && !d[5] |=> ch1Run)
    else $error("ch1 idle");
  AST_CH0_SET: assert property (sw && d[6] && !d[4] |=> ch0Run)
    else $error("ch0 idle");
  AST_CH0_CLR: assert property (sw && !d[6] && !d[4] |=> !ch0Run)
    else $error("ch0 runs");
  AST_DONE: assert property (eng.ch0Done && !(sw && d[6] && !d[4]) |=> !ch0Run)
    else $error("ch0 after done");
  AST_NMI: assert property (nmiFall |=> !ch0Run && !ch1Run)
    else $error("runs after nmi");
  AST_MODE: assert property (req.wr && req.addr == MODE_ADDR |=> {dstMode, srcMode} == $past(d[5:2]))
    else $error("mode lost");
  AST_KEEP: assert property (sw && d[5] && !(d[6] && !d[4]) && !eng.ch1Done |=> $stable(ch1Run))
    else $error("ch1 moved");
endmodule : dmacm_chk
bind dmacm_ctrl dmacm_chk u_chk (.clk, .resetn, .req, .rdata, .nmiN, .eng, .ch0Run, .ch1Run,
  .srcMode, .dstMode);
`default_nettype wire

// [bench/dmacm_ctrl_tb.sv]
// dmacm_ctrl_tb: self-checking bench for dmacm_ctrl
// assumes package, design, model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module dmacm_ctrl_tb;
  import dmacm_pkg::*;
  localparam logic [7:0] ST = STATUS_ADDR;
  logic clk = 0, resetn = 0, nmiN = 1, step = 0, ld = 0;
  logic [1:0] fin = '0;
  dmacm_req_t req = '0;
  dmacm_eng_t eng;
  logic [7:0] rdata;
  logic ch0Run, ch1Run, irq0, irq1, sIo, dIo;
  dmacm_mode_t sM, dM;
  logic [19:0] sA, dA;
  int miscompares = 0, tests_run = 0;
  // clock, design and engine stand-in
  initial forever #10 clk = ~clk;
  dmacm_ctrl dut (.clk, .resetn, .req, .rdata, .nmiN, .eng, .srcLoad(ld), .srcLoadVal(20'h00100),
    .dstLoad(ld), .dstLoadVal(20'h00100), .ch0Run, .ch1Run, .ch0IrqReq(irq0), .ch1IrqReq(irq1),
    .srcMode(sM), .dstMode(dM), .srcIsIo(sIo), .dstIsIo(dIo), .srcAddr(sA), .dstAddr(dA));
  dmacm_eng_model eng_m (.clk, .ch0Run, .ch1Run, .step, .fin, .eng);
  // one-cycle register strobes
  task automatic wr(input logic [7:0] a, v);
    @(negedge clk) req <= '{1'b1, 1'b0, a, v};
    @(negedge clk) req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) req <= '0;
    `CHK(rdata, e)
  endtask : rd
  task automatic t_reset;
    rd(ST, 8'h30);
    rd(MODE_ADDR, 8'h00);
    `CHK({ch0Run, ch1Run, irq0, irq1}, 4'h0)
    $display("reset test ends");
  endtask : t_reset
  task automatic t_enable;
    wr(ST, 8'h4C);
    rd(ST, 8'h7D);
    `CHK({ch0Run, irq1}, 2'h3)
    wr(ST, 8'h90);
    rd(ST, 8'hF1);
    wr(ST, 8'h20);
    rd(ST, 8'hB1);
    wr(ST, 8'hF1);
    rd(ST, 8'hB1);
    wr(ST, 8'h10);
    rd(ST, 8'h31);
    $display("enable test ends");
  endtask : t_enable
  task automatic t_nmi;
    wr(ST, 8'h60);
    @(negedge clk) nmiN = 0;
    repeat (6) @(negedge clk);
    rd(ST, 8'h70);
    `CHK(ch0Run, 1'b0)
    nmiN = 1;
    wr(ST, 8'h60);
    rd(ST, 8'h71);
    $display("nmi test ends");
  endtask : t_nmi
  task automatic t_done;
    wr(ST, 8'hCC);
    for (int c = 0; c < 2; c++) begin
      @(negedge clk) fin[c] = 1'b1;
      @(negedge clk) fin = 2'h0;
      repeat (2) @(negedge clk);
      `CHK({ch0Run, ch1Run, irq0, irq1}, c == 0 ? 4'h6 : 4'h3)
    end
    $display("done test ends");
  endtask : t_done
  task automatic t_mode;
    logic [7:0] v;
    logic [19:0] e;
    wr(ST, 8'h60);
    for (int m = 0; m < 4; m++) begin
      v = {2'h0, 2'(m), 2'(m), 2'h0};
      e = m == 0 ? 20'h00102 : m == 1 ? 20'h000FE : 20'h00100;
      wr(MODE_ADDR, v);
      rd(MODE_ADDR, v);
      `CHK({sIo, dIo}, {2{m == 3}})
      @(negedge clk) ld = 1;
      @(negedge clk) ld = 0;
      step = 1;
      repeat (2) @(negedge clk);
      step = 0;
      repeat (3) @(negedge clk);
      `CHK({sA, dA}, {e, e})
    end
    $display("mode test ends");
  endtask : t_mode
  task automatic final_report;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1;
    t_reset;
    t_enable;
    t_nmi;
    t_done;
    t_mode;
    final_report;
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule : dmacm_ctrl_tb
`default_nettype wire

// [bench/dmacm_eng_model.sv]
// dmacm_eng_model: transfer engine stand-in
// assumes bench requests change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module dmacm_eng_model (
  input wire logic clk,
  input wire logic ch0Run,
  input wire logic ch1Run,
  input wire logic step,
  input wire logic [1:0] fin,
  output var dmacm_pkg::dmacm_eng_t eng
);
  import dmacm_pkg::*;
  // bytes and terminal counts only while a channel may run
  always @(posedge clk) begin
    eng.ch0Byte <= step && ch0Run;
    eng.ch0Done <= fin[0] && ch0Run;
    eng.ch1Done <= fin[1] && ch1Run;
  end
endmodule : dmacm_eng_model
`default_nettype wire

// [design/dmacm_addr_step.sv]
// dmacm_addr_step: one channel 0 address counter stepped by its mode
// assumes load and step come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module dmacm_addr_step #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  input wire logic step,
  input wire dmacm_pkg::dmacm_mode_t mode,
  output logic [W-1:0] addr
);
  import dmacm_pkg::*;

  typedef struct packed {
    logic [W-1:0] addr;
  } dmacm_step_t;

  dmacm_step_t state_ff;
  dmacm_step_t nxt_state;

  // load wins; otherwise step by mode after each byte
  always_comb begin
    nxt_state = state_ff;
    if (load) begin
      nxt_state.addr = loadVal;
    end else if (step) begin
      unique case (mode)
        MEM_INC: nxt_state.addr = state_ff.addr + W'(1);
        MEM_DEC: nxt_state.addr = state_ff.addr - W'(1);
        MEM_FIX: nxt_state.addr = state_ff.addr;
        IO_FIX: nxt_state.addr = state_ff.addr;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign addr = state_ff.addr;
endmodule : dmacm_addr_step
`default_nettype wire

// [design/dmacm_ctrl.sv]
// dmacm_ctrl: enable, interrupt request and channel 0 mode control of a two-channel dma
// assumes the cpu i/o port gives one-cycle rd/wr strobes; nmi arrives as a pin, active low
// Behaviour
// - gated write of 1 enables channel 1 and sets main enable
// - gated write of 0 stops channel 1, state kept for restart
// - gated write of 1 enables channel 0 and sets main enable
// - gated write of 0 stops channel 0 transfers
// - terminal count clears that channel's enable bit
// - enable 0 with interrupt enable 1 raises that channel's request
// - both gate bits always read as 1
// - channel runs only while its enable and main enable are 1
// - nmi clears main enable, halting all dma
// - writing 1 sets main enable even if channel enable was already 1
// - main enable bit position ignores direct writes
// - reset clears channel enables, interrupt enables and main enable
// - destination mode: inc, dec, fixed memory, fixed i/o
// - source mode: inc, dec, fixed memory, fixed i/o
// - reset clears destination mode to memory increment
`timescale 1ns/1ps
`default_nettype none
module dmacm_ctrl #(
  parameter int ADDR_WIDTH = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire dmacm_pkg::dmacm_req_t req,
  output logic [7:0] rdata,
  input wire logic nmiN,
  input wire dmacm_pkg::dmacm_eng_t eng,
  input wire logic srcLoad,
  input wire logic [ADDR_WIDTH-1:0] srcLoadVal,
  input wire logic dstLoad,
  input wire logic [ADDR_WIDTH-1:0] dstLoadVal,
  output logic ch0Run,
  output logic ch1Run,
  output logic ch0IrqReq,
  output logic ch1IrqReq,
  output dmacm_pkg::dmacm_mode_t srcMode,
  output dmacm_pkg::dmacm_mode_t dstMode,
  output logic srcIsIo,
  output logic dstIsIo,
  output logic [ADDR_WIDTH-1:0] srcAddr,
  output logic [ADDR_WIDTH-1:0] dstAddr
);
  import dmacm_pkg::*;

  typedef struct packed {
    logic ch1En;
    logic ch0En;
    logic ch1Ie;
    logic ch0Ie;
    logic mainEn;
    logic [1:0] dstMode;
    logic [1:0] srcMode;
    logic [2:0] nmiSync;
    logic nmiSeen;
    logic [7:0] rdata;
  } dmacm_state_t;

  dmacm_state_t state_ff;
  dmacm_state_t nxt_state;

  // register port decode results
  logic wrStat;
  logic wrMode;
  logic rdStat;
  logic rdMode;
  logic rdOther;

  // gated enable writes, one pair per channel
  logic ch1Gated;
  logic ch0Gated;
  logic ch1SetReq;
  logic ch0SetReq;
  logic ch1ClrReq;
  logic ch0ClrReq;
  logic mainSetReq;

  // nmi synchroniser taps
  logic nmiLowAgreed;
  logic nmiHighAgreed;
  logic nmiEvent;

  // read views and the selected byte
  logic [7:0] statusView;
  logic [7:0] modeView;
  logic [7:0] rdNext;

  // channel 0 byte step shared by both counters
  logic ch0Step;

  // true when the access addresses the given i/o location
  function automatic logic addrHit(input dmacm_req_t r, input logic [7:0] where);
    addrHit = (r.addr == where);
  endfunction : addrHit

  // true when an enable bit is written through its open gate
  function automatic logic gatedWrite(input logic wr, input logic [7:0] d, input int gateBit);
    gatedWrite = wr && !d[gateBit];
  endfunction : gatedWrite

  // status byte as the cpu sees it; gate bits read 1, unused bits read 0
  function automatic logic [7:0] statusImage(input dmacm_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[CH1_EN_BIT] = s.ch1En;
    v[CH0_EN_BIT] = s.ch0En;
    v[CH1_GATE_BIT] = 1'b1;
    v[CH0_GATE_BIT] = 1'b1;
    v[CH1_IE_BIT] = s.ch1Ie;
    v[CH0_IE_BIT] = s.ch0Ie;
    v[MAIN_EN_BIT] = s.mainEn;
    return v;
  endfunction : statusImage

  // mode byte as the cpu sees it; only the two mode fields are kept
  function automatic logic [7:0] modeImage(input logic [1:0] dst, input logic [1:0] src);
    logic [7:0] v;
    v = 8'h00;
    v[DEST_LO_BIT +: 2] = dst;
    v[SRC_LO_BIT +: 2] = src;
    return v & MODE_WMASK;
  endfunction : modeImage

  // a channel moves data only while both enables stand
  function automatic logic chanRun(input logic en, input logic mainOn);
    chanRun = en && mainOn;
  endfunction : chanRun

  // termination request: channel off with its interrupt enabled
  function automatic logic chanIrq(input logic en, input logic ie);
    chanIrq = !en && ie;
  endfunction : chanIrq

  // mode code 3 is the fixed i/o address
  function automatic logic modeIsIo(input logic [1:0] m);
    modeIsIo = (m == IO_FIX);
  endfunction : modeIsIo

  // register port decode; one strobe per access
  assign wrStat = req.wr && addrHit(req, STATUS_ADDR);
  assign wrMode = req.wr && addrHit(req, MODE_ADDR);
  assign rdStat = req.rd && addrHit(req, STATUS_ADDR);
  assign rdMode = req.rd && addrHit(req, MODE_ADDR);
  assign rdOther = req.rd && !rdStat && !rdMode;

  // enable writes pass only an open gate; main enable bit of wdata is never looked at
  assign ch1Gated = gatedWrite(wrStat, req.wdata, CH1_GATE_BIT);
  assign ch0Gated = gatedWrite(wrStat, req.wdata, CH0_GATE_BIT);
  assign ch1SetReq = ch1Gated && req.wdata[CH1_EN_BIT];
  assign ch0SetReq = ch0Gated && req.wdata[CH0_EN_BIT];
  assign ch1ClrReq = ch1Gated && !req.wdata[CH1_EN_BIT];
  assign ch0ClrReq = ch0Gated && !req.wdata[CH0_EN_BIT];
  // a set through either gate restarts dma even if the enable already stood at 1
  assign mainSetReq = ch1SetReq || ch0SetReq;

  // second and third stages must agree before a level counts
  assign nmiLowAgreed = !state_ff.nmiSync[1] && !state_ff.nmiSync[2];
  assign nmiHighAgreed = state_ff.nmiSync[1] && state_ff.nmiSync[2];
  // one event per falling edge; nmiSeen blocks repeats while the pin stays low
  assign nmiEvent = nmiLowAgreed && !state_ff.nmiSeen;

  // read views of both registers
  always_comb begin
    statusView = statusImage(state_ff);
    modeView = modeImage(state_ff.dstMode, state_ff.srcMode);
  end

  // read byte selection; unmapped reads give zero, no read keeps the last byte
  always_comb begin
    rdNext = state_ff.rdata;
    if (rdStat) begin
      rdNext = statusView;
    end else if (rdMode) begin
      rdNext = modeView;
    end else if (rdOther) begin
      rdNext = 8'h00;
    end
  end

  // next-state logic for all control state
  always_comb begin
    nxt_state = state_ff;

    // nmi synchroniser shift and edge memory
    nxt_state.nmiSync = {state_ff.nmiSync[1:0], nmiN};
    if (nmiHighAgreed) begin
      nxt_state.nmiSeen = 1'b0;
    end else if (nmiEvent) begin
      nxt_state.nmiSeen = 1'b1;
    end

    // terminal count clears the enable; main enable untouched
    if (eng.ch1Done) begin
      nxt_state.ch1En = 1'b0;
    end
    if (eng.ch0Done) begin
      nxt_state.ch0En = 1'b0;
    end

    // nmi clears main enable; a set in the same cycle still wins below
    if (nmiEvent) begin
      nxt_state.mainEn = 1'b0;
    end

    // interrupt enables follow every status write, gate or not
    if (wrStat) begin
      nxt_state.ch1Ie = req.wdata[CH1_IE_BIT];
      nxt_state.ch0Ie = req.wdata[CH0_IE_BIT];
    end

    // gated channel 1 write; a clear keeps the channel restartable
    if (ch1SetReq) begin
      nxt_state.ch1En = 1'b1;
    end else if (ch1ClrReq) begin
      nxt_state.ch1En = 1'b0;
    end

    // gated channel 0 write
    if (ch0SetReq) begin
      nxt_state.ch0En = 1'b1;
    end else if (ch0ClrReq) begin
      nxt_state.ch0En = 1'b0;
    end

    // main enable is only ever set indirectly
    if (mainSetReq) begin
      nxt_state.mainEn = 1'b1;
    end

    // mode fields; bits outside the two fields are dropped
    if (wrMode) begin
      nxt_state.dstMode = req.wdata[DEST_LO_BIT +: 2];
      nxt_state.srcMode = req.wdata[SRC_LO_BIT +: 2];
    end

    // registered read data
    nxt_state.rdata = rdNext;
  end

  // state register; reset clears enables and modes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
      state_ff.ch1En <= 1'b0;
      state_ff.ch0En <= 1'b0;
      state_ff.ch1Ie <= 1'b0;
      state_ff.ch0Ie <= 1'b0;
      state_ff.mainEn <= 1'b0;
      state_ff.nmiSeen <= 1'b0;
      state_ff.rdata <= 8'h00;
      state_ff.nmiSync <= 3'h7; // pin idles high, so no false edge out of reset
      state_ff.dstMode <= MODE_RESET;
      state_ff.srcMode <= MODE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // run qualifiers
  assign ch0Run = chanRun(state_ff.ch0En, state_ff.mainEn);
  assign ch1Run = chanRun(state_ff.ch1En, state_ff.mainEn);

  // termination requests are levels, high while the channel stays off
  assign ch0IrqReq = chanIrq(state_ff.ch0En, state_ff.ch0Ie);
  assign ch1IrqReq = chanIrq(state_ff.ch1En, state_ff.ch1Ie);

  // registered read byte
  assign rdata = state_ff.rdata;

  // mode outputs straight from the mode fields
  assign srcMode = dmacm_mode_t'(state_ff.srcMode);
  assign dstMode = dmacm_mode_t'(state_ff.dstMode);
  assign srcIsIo = modeIsIo(state_ff.srcMode);
  assign dstIsIo = modeIsIo(state_ff.dstMode);

  // a byte moves the counters only while channel 0 may run
  assign ch0Step = eng.ch0Byte && ch0Run;

  // channel 0 address counters step only on a byte of a running channel
  dmacm_addr_step #(.W(ADDR_WIDTH)) uSrc (
    .clk(clk),
    .resetn(resetn),
    .load(srcLoad),
    .loadVal(srcLoadVal),
    .step(ch0Step),
    .mode(dmacm_mode_t'(state_ff.srcMode)),
    .addr(srcAddr)
  );

  // destination counter shares the step; its own mode decides the direction
  dmacm_addr_step #(.W(ADDR_WIDTH)) uDst (
    .clk(clk),
    .resetn(resetn),
    .load(dstLoad),
    .loadVal(dstLoadVal),
    .step(ch0Step),
    .mode(dmacm_mode_t'(state_ff.dstMode)),
    .addr(dstAddr)
  );
endmodule : dmacm_ctrl
`default_nettype wire

// [design/dmacm_pkg.sv]
// dmacm_pkg: constants and carrier types for the dma enable and mode control block
// assumes an 8-bit i/o register port with one-cycle read and write strobes
package dmacm_pkg;
  localparam logic [7:0] STATUS_ADDR = 8'h30;
  localparam logic [7:0] MODE_ADDR = 8'h31;
  localparam int CH1_EN_BIT = 7;
  localparam int CH0_EN_BIT = 6;
  localparam int CH1_GATE_BIT = 5;
  localparam int CH0_GATE_BIT = 4;
  localparam int CH1_IE_BIT = 3;
  localparam int CH0_IE_BIT = 2;
  localparam int MAIN_EN_BIT = 0;
  localparam int DEST_LO_BIT = 4;
  localparam int SRC_LO_BIT = 2;
  localparam logic [7:0] MODE_WMASK = 8'h3C;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam int ADDR_W = 20;

  typedef enum logic [1:0] {
    MEM_INC = 2'h0,
    MEM_DEC = 2'h1,
    MEM_FIX = 2'h2,
    IO_FIX = 2'h3
  } dmacm_mode_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmacm_req_t;

  // per-channel engine handshake from the transfer engine
  typedef struct packed {
    logic ch0Done;
    logic ch1Done;
    logic ch0Byte;
  } dmacm_eng_t;
endpackage : dmacm_pkg
